// ### hdl/cpu_clock_select_switch.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
//Contract
// R01: codes 0-5 give main clock divided 1..32; 011x prohibited; top bit picks subclock.
// R02: subclock source, crystal or slow internal, comes from the option strap.
// R03: software must not change the select field while that clock is output.
// R04: change the subclock select bit alone, never with the divider bits.
// R05: software confirms the main oscillator drives main clock before going to subclock.
// R06: cpu clock must exceed four times subclock before selecting subclock.
// R07: switch to subclock completes within one selected subclock period.
// R08: status bit reports the completed switch; software polls it.
// R09: software stops PLL and main-clock peripherals before stopping the oscillator.
// R10: to return, clear stop bit, wait stable flag, then clear select bit alone.
// R11: switch back to divided main clock within one subclock period, then update status.
// R12: no new selection until the previous one is stable.
// R13: status bit 4 reads zero on main clock, one on subclock.
// R14: oscillator stop bit takes effect only once the cpu runs from subclock.
module cpu_clock_select_switch (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic crystal_subclock,
	input wire logic low_speed_internal_clock,
	input wire logic subclock_source_option,
	input wire logic main_osc_stable_flag,
	input wire logic main_source_status,
	output logic cpu_clock_enable,
	output logic cpu_clock_source_status,
	output logic main_osc_enable,
	output logic main_source_select_bit
);
	typedef struct packed {
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
		logic ready;
		logic [clk_sel_pkg::FIELD_W-1:0] field;
		logic osc_stop;
		logic src_sel;
		clk_sel_pkg::clk_mode_t mode;
		logic [clk_sel_pkg::DIV_W-1:0] div_eff;
		logic [clk_sel_pkg::CNT_W-1:0] cnt;
		logic tick;
		logic [2:0] opt_fill;
		logic opt;
	} core_state_t;

	core_state_t st_reg;
	core_state_t st_next;
	logic [clk_sel_pkg::PIN_N-1:0] pins;
	logic addr_phase;
	logic pending;
	logic on_sub;

	clk_pin_if pif ();

	assign pins = {subclock_source_option, main_source_status, main_osc_stable_flag,
		low_speed_internal_clock, crystal_subclock};
	assign pif.subclock_source_option = st_reg.opt;

	clk_pin_sync i_clk_pin_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pins(pins),
		.pif(pif)
	);

	assign addr_phase = hsel & hready & (htrans == clk_sel_pkg::HTRANS_NONSEQ | htrans == 2'h3);
	assign on_sub = (st_reg.mode == clk_sel_pkg::MODE_SUB);
	assign pending = st_reg.field[clk_sel_pkg::SUB_SEL_POS] != on_sub;

	////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;
		st_next.ready = 1'b1;
		st_next.tick = 1'b0;

		// synchroniser flops leave reset at zero, so the strap is trusted only once two
		// edges have filled them; it is taken on the third edge after release, then frozen
		if (!st_reg.opt_fill[2]) begin
			st_next.opt = pif.option_raw; // [R02]
			st_next.opt_fill = {st_reg.opt_fill[1:0], 1'b1};
		end

		// data phase of a write; byte writes are treated as whole-word writes,
		// so keeping the divider bits unchanged on a select-bit change is software's job
		if (st_reg.dp_write) begin
			case (st_reg.dp_addr)
				clk_sel_pkg::CTRL_OFFSET: begin
					st_next.field = hwdata[clk_sel_pkg::FIELD_LSB +: clk_sel_pkg::FIELD_W]; // [R04]
					st_next.osc_stop = hwdata[clk_sel_pkg::OSC_STOP_POS];
				end
				clk_sel_pkg::SRC_OFFSET: begin
					st_next.src_sel = hwdata[clk_sel_pkg::SRC_SEL_POS]; // [R05]
				end
				default: begin
				end
			endcase
		end

		// prohibited divider codes leave the running divider alone
		if (st_next.field[clk_sel_pkg::DIV_W-1:0] <= clk_sel_pkg::DIV_MAX) begin
			st_next.div_eff = st_next.field[clk_sel_pkg::DIV_W-1:0]; // [R01]
		end

		// mode changes only at a rising subclock edge, so within one period [R07] [R11]
		case (st_reg.mode)
			clk_sel_pkg::MODE_MAIN: begin
				if (st_reg.field[clk_sel_pkg::SUB_SEL_POS] && pif.sub_edge) begin
					st_next.mode = clk_sel_pkg::MODE_SUB; // [R07] [R08]
				end
			end
			clk_sel_pkg::MODE_SUB: begin
				if (!st_reg.field[clk_sel_pkg::SUB_SEL_POS] && pif.sub_edge) begin
					st_next.mode = clk_sel_pkg::MODE_MAIN; // [R11]
					st_next.cnt = '0;
				end
			end
			default: begin
				st_next.mode = clk_sel_pkg::MODE_MAIN;
			end
		endcase

		// cpu clock strobe: divided hclk on main, subclock edges on subclock
		if (on_sub) begin
			st_next.tick = pif.sub_edge;
		end else if (st_reg.cnt == '0) begin
			st_next.tick = 1'b1; // [R01]
			st_next.cnt = clk_sel_pkg::CNT_W'((32'h1 << st_next.div_eff) - 32'h1);
		end else begin
			st_next.cnt = st_reg.cnt - 1'b1;
		end

		// address phase: capture and prepare read data from the updated state
		st_next.dp_write = addr_phase & hwrite;
		st_next.dp_addr = haddr[7:0];
		if (addr_phase && !hwrite) begin
			st_next.rdata = '0;
			case (haddr[7:0])
				clk_sel_pkg::CTRL_OFFSET: begin
					st_next.rdata[clk_sel_pkg::FIELD_LSB +: clk_sel_pkg::FIELD_W] = st_next.field;
					st_next.rdata[clk_sel_pkg::CLS_POS] = (st_next.mode == clk_sel_pkg::MODE_SUB); // [R13] [R08]
					st_next.rdata[clk_sel_pkg::OSC_STOP_POS] = st_next.osc_stop;
				end
				clk_sel_pkg::STAT_OFFSET: begin
					st_next.rdata[clk_sel_pkg::STABLE_POS] = pif.main_osc_stable_flag; // [R10]
					st_next.rdata[clk_sel_pkg::OPTION_POS] = st_next.opt;
					st_next.rdata[clk_sel_pkg::PENDING_POS] = pending; // [R12]
					st_next.rdata[clk_sel_pkg::MAIN_SRC_POS] = pif.main_source_status; // [R05]
				end
				clk_sel_pkg::SRC_OFFSET: begin
					st_next.rdata[clk_sel_pkg::SRC_SEL_POS] = st_next.src_sel;
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
			st_reg.field <= clk_sel_pkg::CTRL_RESET[clk_sel_pkg::FIELD_W-1:0];
			st_reg.osc_stop <= clk_sel_pkg::CTRL_RESET[clk_sel_pkg::OSC_STOP_POS];
			st_reg.src_sel <= clk_sel_pkg::SRC_SEL_RESET;
			st_reg.mode <= clk_sel_pkg::MODE_MAIN;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs registered; osc keeps running while the cpu still uses it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			cpu_clock_enable <= 1'b0;
			cpu_clock_source_status <= 1'b0;
			main_osc_enable <= 1'b1;
			main_source_select_bit <= 1'b0;
		end else begin
			hrdata <= st_next.rdata;
			hreadyout <= st_next.ready;
			hresp <= 1'b0;
			cpu_clock_enable <= st_next.tick;
			cpu_clock_source_status <= (st_next.mode == clk_sel_pkg::MODE_SUB); // [R13]
			main_osc_enable <= !(st_next.osc_stop && st_next.mode == clk_sel_pkg::MODE_SUB); // [R14]
			main_source_select_bit <= st_next.src_sel;
		end
	end
endmodule
`default_nettype wire

// ### pkg/clk_sel_pkg.sv
package clk_sel_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STAT_OFFSET = 8'h04;
	localparam logic [7:0] SRC_OFFSET = 8'h08;
	// control register fields
	localparam int FIELD_LSB = 0;
	localparam int FIELD_W = 4;
	localparam int SUB_SEL_POS = 3;
	localparam int DIV_W = 3;
	localparam int CLS_POS = 4;
	localparam int OSC_STOP_POS = 6;
	localparam logic [7:0] CTRL_RESET = 8'h40;
	// status register fields
	localparam int STABLE_POS = 0;
	localparam int OPTION_POS = 1;
	localparam int PENDING_POS = 2;
	localparam int MAIN_SRC_POS = 3;
	// source select register
	localparam int SRC_SEL_POS = 0;
	localparam logic SRC_SEL_RESET = 1'b0;
	// divider codes, legal up to 0101 (fxx/32)
	localparam logic [2:0] DIV_MAX = 3'h5;
	localparam int CNT_W = 5;
	// synchronised pins
	localparam int PIN_XT = 0;
	localparam int PIN_RL = 1;
	localparam int PIN_STABLE = 2;
	localparam int PIN_MAIN_SRC = 3;
	localparam int PIN_OPT = 4;
	localparam int PIN_N = 5;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {
		MODE_MAIN = 2'b01,
		MODE_SUB = 2'b10
	} clk_mode_t;
endpackage

// ### pkg/clk_pin_if.sv
`timescale 1ns/100ps
`default_nettype none
interface clk_pin_if;
	logic subclock_source_option;
	logic sub_edge;
	logic main_osc_stable_flag;
	logic main_source_status;
	logic option_raw;
	modport sync (input subclock_source_option, output sub_edge, output main_osc_stable_flag,
		output main_source_status, output option_raw);
	modport core (output subclock_source_option, input sub_edge, input main_osc_stable_flag,
		input main_source_status, input option_raw);
endinterface
`default_nettype wire

// ### hdl/clk_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module clk_pin_sync (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [clk_sel_pkg::PIN_N-1:0] pins,
	clk_pin_if.sync pif
);
	typedef struct packed {
		logic [clk_sel_pkg::PIN_N-1:0] s1;
		logic [clk_sel_pkg::PIN_N-1:0] s2;
		logic sub_prev;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;
	logic sub_now;

	////////////////////////////////////////////////////////////////
	// first stage feeds only the second stage
	always_comb begin
		st_next = st_reg;
		st_next.s1 = pins;
		st_next.s2 = st_reg.s1;
		st_next.sub_prev = sub_now;
	end

	// subclock source is taken from the option strap, not the select field [R02]
	assign sub_now = pif.subclock_source_option ? st_reg.s2[clk_sel_pkg::PIN_RL] : st_reg.s2[clk_sel_pkg::PIN_XT];
	assign pif.sub_edge = sub_now & ~st_reg.sub_prev;
	assign pif.main_osc_stable_flag = st_reg.s2[clk_sel_pkg::PIN_STABLE];
	assign pif.main_source_status = st_reg.s2[clk_sel_pkg::PIN_MAIN_SRC];
	assign pif.option_raw = st_reg.s2[clk_sel_pkg::PIN_OPT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule
`default_nettype wire

// ### testbench/clk_sel_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module clk_sel_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic cpu_clock_source_status,
	input wire logic main_osc_enable,
	input wire logic main_source_select_bit
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_req(logic w, logic [7:0] a);
		hsel && hready && htrans[1] && hwrite == w && haddr[7:0] == a;
	endsequence
	sequence s_src_wr;
		s_req(1'b1, clk_sel_pkg::SRC_OFFSET) ##1 1'b1;
	endsequence
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("error response seen");
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("wait state seen");
	// status and the oscillator gate are registered on the same edge; the check allows one edge of slack
	property p_osc_stop; !main_osc_enable |-> ##[0:1] cpu_clock_source_status; endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("oscillator stopped on main clock");
	property p_osc_run; $fell(cpu_clock_source_status) |-> main_osc_enable; endproperty
	a_osc_run: assert property (p_osc_run) else $error("main clock back without oscillator");
	property p_ctrl_rd; s_req(1'b0, clk_sel_pkg::CTRL_OFFSET) |=> hrdata[31:7] == 25'h0 && !hrdata[5]; endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read has stray bits");
	property p_stat_rd; s_req(1'b0, clk_sel_pkg::STAT_OFFSET) |=> hrdata[31:4] == 28'h0; endproperty
	a_stat_rd: assert property (p_stat_rd) else $error("status read has stray bits");
	property p_unmapped; s_req(1'b0, 8'h0C) |=> hrdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_src_wr; s_src_wr |=> main_source_select_bit == $past(hwdata[0]); endproperty
	a_src_wr: assert property (p_src_wr) else $error("source select not updated");
endmodule
bind cpu_clock_select_switch clk_sel_checker i_clk_sel_checker (.*);
`default_nettype wire

// ### testbench/cpu_clock_select_switch_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s expected %0h seen %0h", n, e, g); end end
module cpu_clock_select_switch_bench;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic crystal_subclock = 0, low_speed_internal_clock = 0, subclock_source_option = 0;
	logic main_osc_stable_flag = 0, main_source_status = 1, cpu_clock_enable, cpu_clock_source_status;
	logic main_osc_enable, main_source_select_bit;
	logic [3:0] sub_cnt = '0;
	int num_errors = 0, total_checks = 0;
	assign hready = hreadyout;
	cpu_clock_select_switch i_cpu_clock_select_switch (.*);
	initial begin
		forever #12.5 hclk = ~hclk;
	end
	// crystal period is 16 hclk, slow oscillator 8
	always @(posedge hclk) begin
		sub_cnt <= sub_cnt + 4'h1;
		crystal_subclock <= sub_cnt[3];
		low_speed_internal_clock <= sub_cnt[2];
	end
	////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= clk_sel_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(n, e, q)
	endtask
	// the first gap after a divider change may be short, so the second is judged
	task automatic gap(input int e);
		int n;
		for (int i = 0; i < 2; i++) begin
			n = 0;
			@(posedge hclk);
			while (cpu_clock_enable !== 1'b1 && n < 100) begin
				@(posedge hclk);
				n++;
			end
		end
		`CHK("pulse gap", e, n + 1)
	endtask
	// lim is one subclock period plus the edge that registers the status
	task automatic wait_cls(input logic v, input int lim);
		int n;
		n = 0;
		while (cpu_clock_source_status !== v && n < 40) begin
			@(posedge hclk);
			n++;
		end
		`CHK("switch time ok", 1'b1, n <= lim)
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_div;
		for (int d = 0; d < 6; d++) begin
			wr(clk_sel_pkg::CTRL_OFFSET, 32'h40 | d);
			gap(1 << (d + 1) >> 1);
			`CHK("osc on", 1'b1, main_osc_enable)
		end
		wr(clk_sel_pkg::CTRL_OFFSET, 32'h46);
		rd("ctrl prohibited", clk_sel_pkg::CTRL_OFFSET, 32'h46);
		gap(32);
	endtask
	task automatic t_sub;
		// crystal runs at hclk/16, so only divide by 1 or 2 keeps the cpu above four times it
		wr(clk_sel_pkg::CTRL_OFFSET, 32'h41);
		// no pll or main-clock peripherals here, so the stop bit left set from reset is safe
		wr(clk_sel_pkg::CTRL_OFFSET, 32'h49);
		wait_cls(1'b1, 17);
		rd("ctrl sub", clk_sel_pkg::CTRL_OFFSET, 32'h59);
		`CHK("osc stopped", 1'b0, main_osc_enable)
		gap(16);
		wr(clk_sel_pkg::CTRL_OFFSET, 32'h09);
		repeat (3) @(posedge hclk);
		`CHK("osc restarted", 1'b1, main_osc_enable)
		main_osc_stable_flag <= 1'b1;
		repeat (4) @(posedge hclk);
		rd("stat stable", clk_sel_pkg::STAT_OFFSET, 32'h09);
		wr(clk_sel_pkg::CTRL_OFFSET, 32'h01);
		wait_cls(1'b0, 17);
		rd("ctrl main", clk_sel_pkg::CTRL_OFFSET, 32'h01);
		gap(2);
	endtask
	// mid-run reset with the slow internal oscillator strapped in, period 8 hclk
	task automatic t_slow;
		hresetn <= 1'b0;
		subclock_source_option <= 1'b1;
		main_osc_stable_flag <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		`CHK("src reset", 1'b0, main_source_select_bit)
		rd("stat slow", clk_sel_pkg::STAT_OFFSET, 32'h0A);
		// undivided cpu clock is above four times hclk/8
		wr(clk_sel_pkg::CTRL_OFFSET, 32'h48);
		wait_cls(1'b1, 9);
		gap(8);
	endtask
	task automatic t_regs;
		rd("ctrl reset", clk_sel_pkg::CTRL_OFFSET, 32'h40);
		rd("stat reset", clk_sel_pkg::STAT_OFFSET, 32'h08);
		rd("unmapped", 8'h0C, 32'h0);
		wr(clk_sel_pkg::SRC_OFFSET, 32'h1);
		rd("src", clk_sel_pkg::SRC_OFFSET, 32'h1);
		`CHK("src pin", 1'b1, main_source_select_bit)
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_div;
		t_sub;
		t_slow;
		print_verdict;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		print_verdict;
	end
endmodule
`default_nettype wire
